// >>> rtl/dpw_pkg.sv
// package: constants for the deep power-down and wake control block
package dpw_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [5:0] ADDR_POWER_CTRL = 6'h00;
   localparam logic [5:0] ADDR_BACKUP_FIRST = 6'h04;
   localparam logic [5:0] ADDR_BACKUP_LAST = 6'h10;
   localparam logic [5:0] ADDR_START0_ENABLE = 6'h14;
   localparam logic [5:0] ADDR_START0_EDGE = 6'h18;
   localparam logic [5:0] ADDR_START0_CLEAR = 6'h1C;
   localparam logic [5:0] ADDR_START0_STATUS = 6'h20;
   localparam logic [5:0] ADDR_START1_ENABLE = 6'h24;
   localparam logic [5:0] ADDR_START1_EDGE = 6'h28;
   localparam logic [5:0] ADDR_START1_CLEAR = 6'h2C;
   localparam logic [5:0] ADDR_START1_STATUS = 6'h30;
   localparam logic [5:0] ADDR_RTC_MASK = 6'h34;
   // ==========================================================
   // field positions
   localparam int POS_DEEP_PD_ENABLE = 1;
   localparam int POS_DEEP_PD_FLAG = 11;
   localparam int POS_RTC_START = 18;
   localparam int POS_RTC_UNMASK = 0;
   localparam int START_PINS = 12;
   localparam int BACKUP_REGS = 4;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_LOW_NS = 50;
   localparam int WAKE_LOW_CYC = (WAKE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_HOLD_CYC = 16;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_DEEP_SLEEP,
      ST_DEEP_PD,
      ST_WAKE_REGULATOR,
      ST_WAKE_RESET
   } dpw_state_type;
endpackage

// >>> rtl/dpw_top.sv
// module: deep power-down entry, wake sequencing and start logic
`timescale 1ns/10ps
module dpw_top
   import dpw_pkg::*;
#(
   parameter int RESET_HOLD = RESET_HOLD_CYC
) (
   input wire logic clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // core and system side
   input wire logic core_deep_sleep_bit,
   input wire logic wait_for_interrupt_instr,
   input wire logic watchdog_pd_lock,
   input wire logic [START_PINS-1:0] nested_interrupt_controller_pin_enable,
   input wire logic nested_interrupt_controller_rtc_enable,
   input wire logic ext_reset_n,
   input wire logic core_supply_ok,
   // wake sources
   input wire logic wake_pin_n,
   input wire logic rtc_irq,
   input wire logic [START_PINS-1:0] port0_pins,
   // outputs
   output logic [START_PINS-1:0] start_irq,
   output logic rtc_start_irq,
   output logic core_wake,
   output logic core_clock_run,
   output logic regulator_on,
   output logic pins_tristate,
   output logic system_reset
);
   // ==========================================================
   // overview of the register map
   // 0x00 power control: enable bit and wake flag
   // the flag reads back whether a wake reset came since its last clear
   // writing one to the flag bit clears it
   // a wake reset in the same cycle beats that clear
   // 0x04 to 0x10: four backup words, kept across wakes
   // backup words only return to zero on power-on reset
   // 0x14 start block 0 enable, one bit per port pin
   // 0x18 start block 0 edge select, one means rising
   // 0x1C start block 0 clear, write one per bit
   // 0x20 start block 0 status, read only
   // 0x24 to 0x30 the same for start block 1, rtc bit only
   // 0x34 rtc unmask, one lets the rtc end deep power-down
   // unmapped offsets read as zero and ignore writes
   // writes to the status offsets are ignored as well
   // ==========================================================
   // bus timing
   // every access costs exactly one wait cycle
   // the first cycle of a request loads the answer register
   // the second cycle drops waitrequest and the transfer lands
   // read data stand for that one cycle, then go back to zero
   // holding read data in a flop keeps the bus path short
   // the price is a fixed extra cycle on every access
   // a master must drop its request after the accepting edge
   // or the handshake starts a fresh transfer straight away
   // ==========================================================
   // start logic
   // each enabled pin is compared with its previous sample
   // a change in the selected direction sets its status bit
   // the status bit stands until software writes its clear bit or a warm reset clears it
   // an edge in the very cycle of a clear still sets the bit
   // so no wake edge can be lost to a late clear
   // the previous sample follows disabled pins too
   // that stops a stale level firing when a pin is enabled
   // this sampled version needs the clock running
   // a truly clockless front end would sit outside this block
   // the twelve pin bits drive interrupt lines 0 to 11
   // the rtc interrupt sits at bit 18 of start block 1
   // core wake is the status anded with the interrupt enables
   // it is combinational so deep-sleep ends one edge later
   // ==========================================================
   // power sequencer
   // wfi with the deep-sleep bit set leaves the active state
   // with the enable bit set, no lock and a high wake pin
   // the sequencer goes to deep power-down
   // otherwise the core only drops to deep-sleep
   // falling back to deep-sleep keeps the core recoverable
   // by the start logic when entry is refused
   // a low wake pin at entry would wake at once, so it is refused
   // in deep power-down the regulator is off and pins float
   // the external reset pin has no effect in that state
   // a wake pin low for five samples ends the mode
   // a shorter glitch resets the low counter and is ignored
   // the low counter saturates so a long hold cannot wrap
   // an unmasked rtc interrupt ends the mode as well
   // both causes mark the coming reset as a wake reset
   // the regulator then comes back up
   // the sequencer waits for the core supply to be good
   // and then holds the warm reset for a set number of cycles
   // the hold length is a parameter, shortened in simulation
   // ==========================================================
   // warm reset
   // clears the enable bit and both start blocks
   // keeps the backup words, the rtc unmask and the flag
   // the flag is set when the reset came from a wake
   // an external reset in active or deep-sleep uses the same path
   // but leaves the flag as it was, so boot code can tell apart
   // a power-on reset clears every register, backup included
   // ==========================================================
   // hazards and limits
   // the sequencer trusts the core supply input to be glitch free
   // a drop of that input while waiting is simply waited out
   // core wake seen in deep power-down does nothing
   // only the wake pin and the rtc have a path out of it
   // a bus write during the warm reset may be overridden
   // by the reset values applied on its last cycle
   // software should wait for the reset to end before access
   // the rtc interrupt is a level, so software must clear it
   // before the next entry, or the next entry wakes at once
   // the wake pin counter starts from zero at every entry
   // all pin and core inputs are taken as synchronous
   // they must come from flops in this clock domain
   // ==========================================================
   // everything below is one state struct
   // one combinational process fills the next copy
   // one clocked process registers it
   // ==========================================================
   // state
   typedef struct packed {
      dpw_state_type state;
      logic [3:0] wake_cnt;
      logic [7:0] rst_cnt;
      logic wake_by_pd;
      logic deep_pd_enable;
      logic flag;
      logic [BACKUP_REGS-1:0][31:0] backup;
      logic [START_PINS-1:0] s0_en;
      logic [START_PINS-1:0] s0_pol;
      logic [START_PINS-1:0] s0_stat;
      logic [START_PINS-1:0] pins_prev;
      logic s1_en;
      logic s1_pol;
      logic s1_stat;
      logic rtc_prev;
      logic rtc_unmask;
      logic ack;
      logic [31:0] rdata;
   } dpw_regs_type;

   localparam logic [3:0] WAKE_LOW_CNT = 4'(WAKE_LOW_CYC);
   localparam logic [7:0] RESET_HOLD_CNT = 8'(RESET_HOLD);

   dpw_regs_type r_q;
   dpw_regs_type r_d;

   logic access;
   logic wr_hit;
   logic [START_PINS-1:0] s0_event;
   logic s1_event;
   logic [START_PINS-1:0] s0_clr;
   logic s1_clr;
   logic wake_pin_event;
   logic rtc_pd_event;
   logic [2:0] bk_idx;

   // ==========================================================
   // bus handshake: one wait cycle, answer on the next edge
   assign access = avs_read | avs_write;
   assign avs_waitrequest = access & ~r_q.ack;
   assign wr_hit = avs_write & r_q.ack;
   assign avs_readdata = r_q.rdata;
   assign bk_idx = 3'((avs_address - ADDR_BACKUP_FIRST) >> 2);

   // ==========================================================
   // start logic edge events and wake causes
   always_comb begin
      // sampled edges stand in for the pin-clocked edge flops
      for (int i = 0; i < START_PINS; i++) begin
         s0_event[i] = r_q.s0_en[i] & (r_q.s0_pol[i] ? (port0_pins[i] & ~r_q.pins_prev[i])
                                                    : (~port0_pins[i] & r_q.pins_prev[i]));
      end
      s1_event = r_q.s1_en & (r_q.s1_pol ? (rtc_irq & ~r_q.rtc_prev)
                                         : (~rtc_irq & r_q.rtc_prev));
      s0_clr = (wr_hit && avs_address == ADDR_START0_CLEAR) ?
               avs_writedata[START_PINS-1:0] : '0;
      s1_clr = wr_hit && avs_address == ADDR_START1_CLEAR && avs_writedata[POS_RTC_START];
      wake_pin_event = (r_q.wake_cnt >= WAKE_LOW_CNT - 4'h1) & ~wake_pin_n;
      rtc_pd_event = rtc_irq & r_q.rtc_unmask;
   end

   // ==========================================================
   // next state
   always_comb begin
      r_d = r_q;
      r_d.ack = access & ~r_q.ack;
      r_d.pins_prev = port0_pins;
      r_d.rtc_prev = rtc_irq;
      // set beats clear so an edge in the clear cycle survives
      r_d.s0_stat = (r_q.s0_stat & ~s0_clr) | s0_event;
      r_d.s1_stat = (r_q.s1_stat & ~s1_clr) | s1_event;

      // register writes
      if (wr_hit) begin
         unique case (avs_address)
            ADDR_POWER_CTRL: begin
               r_d.deep_pd_enable = avs_writedata[POS_DEEP_PD_ENABLE];
               if (avs_writedata[POS_DEEP_PD_FLAG]) begin
                  r_d.flag = 1'b0;
               end
            end
            ADDR_START0_ENABLE: r_d.s0_en = avs_writedata[START_PINS-1:0];
            ADDR_START0_EDGE: r_d.s0_pol = avs_writedata[START_PINS-1:0];
            ADDR_START1_ENABLE: r_d.s1_en = avs_writedata[POS_RTC_START];
            ADDR_START1_EDGE: r_d.s1_pol = avs_writedata[POS_RTC_START];
            ADDR_RTC_MASK: r_d.rtc_unmask = avs_writedata[POS_RTC_UNMASK];
            default: begin
               if (avs_address >= ADDR_BACKUP_FIRST && avs_address <= ADDR_BACKUP_LAST
                   && avs_address[1:0] == 2'b00) begin
                  r_d.backup[bk_idx[1:0]] = avs_writedata;
               end
            end
         endcase
      end

      // register reads, unmapped reads return zero
      r_d.rdata = WORD_ZERO;
      if (avs_read & ~r_q.ack) begin
         unique case (avs_address)
            ADDR_POWER_CTRL: begin
               r_d.rdata[POS_DEEP_PD_ENABLE] = r_q.deep_pd_enable;
               r_d.rdata[POS_DEEP_PD_FLAG] = r_q.flag;
            end
            ADDR_START0_ENABLE: r_d.rdata[START_PINS-1:0] = r_q.s0_en;
            ADDR_START0_EDGE: r_d.rdata[START_PINS-1:0] = r_q.s0_pol;
            ADDR_START0_STATUS: r_d.rdata[START_PINS-1:0] = r_q.s0_stat;
            ADDR_START1_ENABLE: r_d.rdata[POS_RTC_START] = r_q.s1_en;
            ADDR_START1_EDGE: r_d.rdata[POS_RTC_START] = r_q.s1_pol;
            ADDR_START1_STATUS: r_d.rdata[POS_RTC_START] = r_q.s1_stat;
            ADDR_RTC_MASK: r_d.rdata[POS_RTC_UNMASK] = r_q.rtc_unmask;
            default: begin
               if (avs_address >= ADDR_BACKUP_FIRST && avs_address <= ADDR_BACKUP_LAST
                   && avs_address[1:0] == 2'b00) begin
                  r_d.rdata = r_q.backup[bk_idx[1:0]];
               end
            end
         endcase
      end

      // power sequencer
      unique case (r_q.state)
         ST_ACTIVE: begin
            if (wait_for_interrupt_instr && core_deep_sleep_bit) begin
               // a lock or a low wake pin leaves the core in deep-sleep instead
               if (r_q.deep_pd_enable && !watchdog_pd_lock && wake_pin_n) begin
                  r_d.state = ST_DEEP_PD;
                  r_d.wake_cnt = 4'h0;
               end else if (!r_q.deep_pd_enable || !watchdog_pd_lock) begin
                  r_d.state = ST_DEEP_SLEEP;
               end else begin
                  r_d.state = ST_DEEP_SLEEP;
               end
            end
         end
         ST_DEEP_SLEEP: begin
            if (core_wake) begin
               r_d.state = ST_ACTIVE;
            end
         end
         ST_DEEP_PD: begin
            // external reset pin has no path out of this state
            r_d.wake_cnt = wake_pin_n ? 4'h0 :
                           (r_q.wake_cnt == 4'hF ? r_q.wake_cnt : r_q.wake_cnt + 4'h1);
            if (wake_pin_event || rtc_pd_event) begin
               r_d.state = ST_WAKE_REGULATOR;
               r_d.wake_by_pd = 1'b1;
            end
         end
         ST_WAKE_REGULATOR: begin
            if (core_supply_ok) begin
               r_d.state = ST_WAKE_RESET;
               r_d.rst_cnt = 8'h00;
            end
         end
         ST_WAKE_RESET: begin
            r_d.rst_cnt = r_q.rst_cnt + 8'h01;
            if (r_q.rst_cnt == RESET_HOLD_CNT - 8'h01) begin
               // warm reset: retention registers survive, the rest go to defaults
               r_d.state = ST_ACTIVE;
               r_d.deep_pd_enable = 1'b0;
               r_d.s0_en = '0;
               r_d.s0_pol = '0;
               r_d.s0_stat = '0;
               r_d.s1_en = 1'b0;
               r_d.s1_pol = 1'b0;
               r_d.s1_stat = 1'b0;
               r_d.flag = r_q.flag | r_q.wake_by_pd;
               r_d.wake_by_pd = 1'b0;
            end
         end
         default: r_d.state = ST_ACTIVE;
      endcase

      // external reset pin in active or deep-sleep: reset with no flag
      if (!ext_reset_n && r_q.state != ST_DEEP_PD && r_q.state != ST_WAKE_RESET
          && r_q.state != ST_WAKE_REGULATOR) begin
         r_d.state = ST_WAKE_RESET;
         r_d.rst_cnt = 8'h00;
         r_d.wake_by_pd = 1'b0;
      end
   end

   // ==========================================================
   // state register: power-on reset clears everything
   always_ff @(posedge clk) begin
      if (reset) begin
         r_q <= '0;
         r_q.state <= ST_ACTIVE;
         r_q.pins_prev <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // ==========================================================
   // outputs
   assign start_irq = r_q.s0_stat;
   assign rtc_start_irq = r_q.s1_stat;
   assign core_wake = |(r_q.s0_stat & nested_interrupt_controller_pin_enable) | (r_q.s1_stat & nested_interrupt_controller_rtc_enable);
   assign core_clock_run = r_q.state == ST_ACTIVE;
   assign regulator_on = r_q.state != ST_DEEP_PD;
   assign pins_tristate = r_q.state == ST_DEEP_PD;
   assign system_reset = r_q.state == ST_WAKE_RESET;
endmodule

// >>> dv/dpw_checker_assertions.sv
// checker: concurrent properties watching the power sequencer ports
`timescale 1ns/10ps
module dpw_checker
   import dpw_pkg::*;
#(
   parameter int RESET_HOLD = RESET_HOLD_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic core_deep_sleep_bit,
   input wire logic wait_for_interrupt_instr,
   input wire logic watchdog_pd_lock,
   input wire logic [START_PINS-1:0] nested_interrupt_controller_pin_enable,
   input wire logic nested_interrupt_controller_rtc_enable,
   input wire logic ext_reset_n,
   input wire logic wake_pin_n,
   input wire logic rtc_irq,
   input wire logic [START_PINS-1:0] start_irq,
   input wire logic rtc_start_irq,
   input wire logic core_wake,
   input wire logic regulator_on,
   input wire logic pins_tristate,
   input wire logic system_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // length of the running warm reset pulse
   int hold_q;
   always_ff @(posedge clk) begin
      if (reset || !system_reset) hold_q <= 0;
      else hold_q <= hold_q + 1;
   end
   a_wait_once: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait not exactly one cycle");
   a_lock_blocks: assert property (
      wait_for_interrupt_instr && core_deep_sleep_bit && watchdog_pd_lock && !pins_tristate
      |=> !pins_tristate) else $error("deep power-down entered while locked");
   // reset pin and a high wake pin must leave the mode alone
   a_pd_holds: assert property (
      pins_tristate && wake_pin_n && $past(wake_pin_n) && !rtc_irq && !$past(rtc_irq)
      |=> pins_tristate) else $error("deep power-down left without wake");
   a_wake_pulse: assert property (
      (pins_tristate && !wake_pin_n && !rtc_irq) [*5] |-> ##[1:2] !pins_tristate)
      else $error("wake pulse ignored");
   a_pins_pair: assert property (
      pins_tristate != regulator_on) else $error("regulator and tristate disagree");
   a_hold_len: assert property (
      $fell(system_reset) |-> hold_q == RESET_HOLD) else $error("warm reset length wrong");
   a_wake_combo: assert property (
      core_wake == ((|(start_irq & nested_interrupt_controller_pin_enable)) || (rtc_start_irq && nested_interrupt_controller_rtc_enable)))
      else $error("core wake does not follow enabled status");
   a_status_stays: assert property (
      !avs_write && !system_reset && ext_reset_n
      |=> (start_irq & $past(start_irq)) == $past(start_irq)) else $error("status bit lost");
   c_pd_exit: cover property (pins_tristate ##1 !pins_tristate);
   c_warm_reset: cover property ($fell(system_reset));
   c_pin_wake: cover property (|start_irq && core_wake);
endmodule
bind dpw_top dpw_checker #(.RESET_HOLD(RESET_HOLD)) u_chk (.clk, .reset, .avs_read,
   .avs_write, .avs_waitrequest, .core_deep_sleep_bit, .wait_for_interrupt_instr,
   .watchdog_pd_lock, .nested_interrupt_controller_pin_enable, .nested_interrupt_controller_rtc_enable, .ext_reset_n, .wake_pin_n,
   .rtc_irq, .start_irq, .rtc_start_irq, .core_wake, .regulator_on, .pins_tristate,
   .system_reset);

// >>> dv/dpw_wake_model.sv
// wake model: external wake pin with pull-up and the always-on rtc
`timescale 1ns/10ps
module dpw_wake_model (
   input wire logic clk,
   output logic wake_pin_n,
   output logic rtc_irq
);
   // pin idles high through its pull-up, rtc quiet
   initial begin
      wake_pin_n = 1'b1;
      rtc_irq = 1'b0;
   end
   // low for n edges; short counts exist to probe the minimum width
   task pulse(input int n);
      wake_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      wake_pin_n <= 1'b1;
   endtask
   // match after n clocks, level until software clears it
   task match(input int n);
      repeat (n) @(posedge clk);
      rtc_irq <= 1'b1;
   endtask
   task clear_irq;
      rtc_irq <= 1'b0;
   endtask
endmodule

// >>> dv/testbench.sv
// testbench: random and corner runs of the power sequencer
`timescale 1ns/10ps
module testbench;
   import dpw_pkg::*;
   localparam logic [31:0] FLAG = 32'h1 << POS_DEEP_PD_FLAG;
   localparam logic [31:0] R18 = 32'h1 << POS_RTC_START;
   logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, bk [4];
   logic core_deep_sleep_bit = 1'b0, wait_for_interrupt_instr = 1'b0, watchdog_pd_lock = 1'b0;
   logic nested_interrupt_controller_rtc_enable = 1'b0, ext_reset_n = 1'b1, core_supply_ok = 1'b0;
   logic [11:0] nested_interrupt_controller_pin_enable = 12'h0, port0_pins = 12'h0, start_irq, e, p0, en, eg;
   logic wake_pin_n, rtc_irq, rtc_start_irq, core_wake, core_clock_run, regulator_on;
   logic pins_tristate, system_reset;
   int miscompares = 0, checked = 0;
   dpw_top #(.RESET_HOLD(2)) dut (.clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .core_deep_sleep_bit,
      .wait_for_interrupt_instr, .watchdog_pd_lock, .nested_interrupt_controller_pin_enable, .nested_interrupt_controller_rtc_enable,
      .ext_reset_n, .core_supply_ok, .wake_pin_n, .rtc_irq, .port0_pins, .start_irq,
      .rtc_start_irq, .core_wake, .core_clock_run, .regulator_on, .pins_tristate,
      .system_reset);
   dpw_wake_model wm (.clk, .wake_pin_n, .rtc_irq);
   always #5 clk = ~clk;
   // ==========================================================
   // helpers
   task give_verdict;
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // hold the request until waitrequest is seen low; a gap edge follows
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      // a bus that never answers counts against the run
      if (n >= 50) miscompares++;
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task rc(input logic [5:0] a, input logic [31:0] ex);
      bus(1'b0, a, 32'h0);
      cmp($sformatf("reg %h", a), ex, rv);
   endtask
   function logic [11:0] hits(input logic [11:0] n, g, a, b);
      return n & ((g & ~a & b) | (~g & a & ~b));
   endfunction
   // software entry order: enable, then deep-sleep bit and wfi
   task enter_pd;
      bus(1'b1, ADDR_POWER_CTRL, 32'h1 << POS_DEEP_PD_ENABLE);
      core_deep_sleep_bit <= 1'b1;
      wait_for_interrupt_instr <= 1'b1;
      @(posedge clk);
      wait_for_interrupt_instr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h0EA1));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rc(ADDR_POWER_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bk[i] = $urandom;
         bus(1'b1, ADDR_BACKUP_FIRST + 6'(4 * i), bk[i]);
      end
      rc(6'h3C, 32'h0);
      // active-mode start logic, first pass with every pin enabled
      for (int k = 0; k < 8; k++) begin
         p0 = 12'($urandom);
         en = (k == 0) ? 12'hFFF : 12'($urandom);
         eg = 12'($urandom);
         port0_pins <= p0;
         bus(1'b1, ADDR_START0_ENABLE, 32'(en));
         bus(1'b1, ADDR_START0_EDGE, 32'(eg));
         bus(1'b1, ADDR_START0_CLEAR, 32'hFFF);
         e = 12'($urandom);
         port0_pins <= e;
         nested_interrupt_controller_pin_enable <= 12'($urandom);
         repeat (3) @(posedge clk);
         e = hits(en, eg, p0, e);
         cmp("core_wake", 32'(|(e & nested_interrupt_controller_pin_enable)), 32'(core_wake));
         bus(1'b1, ADDR_START0_STATUS, 32'hFFF);
         cmp("start_irq", 32'(e), 32'(start_irq));
         bus(1'b1, ADDR_START0_CLEAR, 32'(e));
         cmp("cleared", 32'h0, 32'(start_irq));
      end
      // locked entry falls to deep-sleep; rtc start input wakes it
      bus(1'b1, ADDR_START1_ENABLE, R18);
      bus(1'b1, ADDR_START1_EDGE, R18);
      bus(1'b1, ADDR_START1_CLEAR, R18);
      nested_interrupt_controller_rtc_enable <= 1'b1;
      watchdog_pd_lock <= 1'b1;
      enter_pd;
      cmp("locked_tristate", 32'h0, 32'(pins_tristate));
      cmp("sleep_clock", 32'h0, 32'(core_clock_run));
      wm.match(3);
      repeat (3) @(posedge clk);
      cmp("rtc_start_irq", 32'h1, 32'(rtc_start_irq));
      cmp("woken_clock", 32'h1, 32'(core_clock_run));
      wm.clear_irq;
      core_deep_sleep_bit <= 1'b0;
      watchdog_pd_lock <= 1'b0;
      bus(1'b1, ADDR_START1_CLEAR, R18);
      // deep power-down: masked then unmasked rtc, short and full pulses
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, ADDR_RTC_MASK, 32'(m));
         enter_pd;
         cmp("tristate", 32'h1, 32'(pins_tristate));
         cmp("regulator", 32'h0, 32'(regulator_on));
         ext_reset_n <= 1'b0;
         wm.pulse(4);
         ext_reset_n <= 1'b1;
         repeat (2) @(posedge clk);
         cmp("short_pulse", 32'h1, 32'(pins_tristate));
         wm.match(2);
         repeat (4) @(posedge clk);
         cmp("rtc_wake", 32'(m == 0), 32'(pins_tristate));
         wm.clear_irq;
         @(posedge clk);
         if (m == 0) wm.pulse(5);
         core_supply_ok <= 1'b1;
         repeat (100) if (system_reset !== 1'b1) @(posedge clk);
         repeat (100) if (system_reset !== 1'b0) @(posedge clk);
         core_supply_ok <= 1'b0;
         core_deep_sleep_bit <= 1'b0;
         @(posedge clk);
         rc(ADDR_POWER_CTRL, FLAG);
         for (int i = 0; i < 4; i++) rc(ADDR_BACKUP_FIRST + 6'(4 * i), bk[i]);
         rc(ADDR_START1_ENABLE, 32'h0);
         ext_reset_n <= 1'b0;
         repeat (2) @(posedge clk);
         ext_reset_n <= 1'b1;
         repeat (100) if (system_reset !== 1'b0) @(posedge clk);
         repeat (2) @(posedge clk);
         rc(ADDR_POWER_CTRL, FLAG);
         bus(1'b1, ADDR_POWER_CTRL, FLAG);
         rc(ADDR_POWER_CTRL, 32'h0);
      end
      give_verdict;
   end
   // a hang shows up as a mismatch
   initial begin
      #200000;
      miscompares++;
      give_verdict;
   end
endmodule
